/* File: hdl/dti_map.svh */
`ifndef DTI_MAP_SVH
`define DTI_MAP_SVH

// byte addresses of the register words on the apb
`define DTI_OFF_T1_EOI    8'h0c
`define DTI_OFF_T1_STAT   8'h10
`define DTI_OFF_T2_LOAD   8'h14
`define DTI_OFF_T2_COUNT  8'h18
`define DTI_OFF_T2_CTRL   8'h1c
`define DTI_OFF_T2_EOI    8'h20
`define DTI_OFF_IRQ_STAT  8'h24
`define DTI_OFF_IRQ_MASK  8'h28

// control register fields
`define DTI_CTRL_EN_BIT   0
`define DTI_CTRL_MODE_BIT 1
`define DTI_CTRL_MASK_BIT 2

// interrupt status and mask bit positions
`define DTI_IRQ_T1_BIT    0
`define DTI_IRQ_T2_BIT    1
`define DTI_IRQ_NUM       2

// counter constants and reset values
`define DTI_CNT_MAX       24'hff_ffff
`define DTI_CNT_ZERO      24'h00_0000
`define DTI_CNT_ONE       24'h00_0001
`define DTI_CNT_MSB       23
`define DTI_WORD_ZERO     32'h0000_0000
`define DTI_PAD_ZERO      8'h00

`endif

/* File: hdl/dti_pkg.sv */
package dti_pkg;

   // count and reload width of the second timer
   typedef logic [23:0] dti_cnt_t;

   // second timer control word, bit 2 down to bit 0
   typedef struct packed {
      logic mask;   // interrupt suppressed when set
      logic mode;   // 1 user-defined count, 0 free-running
      logic en;     // timer running
   } dti_ctrl_s;

   // state of the down counter
   typedef struct packed {
      dti_cnt_t cnt;
      logic     run;
      logic     expire;
   } dti_tmr_s;

   // state of one sticky interrupt flag
   typedef struct packed {
      logic q;
   } dti_flag_s;

   // state of the register slice
   typedef struct packed {
      logic        pready;
      logic        pslverr;
      logic [31:0] prdata;
      dti_cnt_t    load;
      dti_ctrl_s   ctrl;
      logic [1:0]  mask;
      logic        irq;
   } dti_regs_s;

endpackage

/* File: hdl/dti_flag.sv */
`timescale 1ns/1ps
`include "dti_map.svh"

module dti_flag
   import dti_pkg::*;
(
   input  wire logic pclk,     // system clock
   input  wire logic presetn,  // async reset, active low
   input  wire logic set,      // event pulse
   input  wire logic clr,      // clear request
   output logic      q         // sticky flag
);

   dti_flag_s st_q;
   dti_flag_s st_d;

   // set beats clear so an event in the clearing cycle is kept
   always_comb begin
      st_d = st_q;
      if (set) begin
         st_d.q = 1'b1;
      end else if (clr) begin
         st_d.q = 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign q = st_q.q;

endmodule // dti_flag

/* File: hdl/dti_timer24.sv */
`timescale 1ns/1ps
`include "dti_map.svh"

module dti_timer24
   import dti_pkg::*;
(
   input  wire logic      pclk,     // system clock
   input  wire logic      presetn,  // async reset, active low
   input  wire logic      en,       // run when high
   input  wire logic      mode,     // 1 reload value, 0 free-running
   input  wire dti_cnt_t  reload,   // user reload value
   output dti_cnt_t       count,    // live count
   output logic           expire    // one-cycle pulse at wrap
);

   dti_tmr_s st_q;
   dti_tmr_s st_d;
   dti_cnt_t start;

   // free-running always restarts from the top of the range
   assign start = mode ? reload : `DTI_CNT_MAX;

   // a fresh enable loads first, so a stale count never fires
   always_comb begin
      st_d        = st_q;
      st_d.run    = en;
      st_d.expire = 1'b0;
      if (en && !st_q.run) begin
         st_d.cnt = start;
      end else if (en) begin
         if (st_q.cnt == `DTI_CNT_ZERO) begin
            st_d.expire = 1'b1;
            st_d.cnt    = start;
         end else begin
            st_d.cnt = st_q.cnt - `DTI_CNT_ONE;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign count  = st_q.cnt;
   assign expire = st_q.expire;

endmodule // dti_timer24

/* File: hdl/dti_regs.sv */
// Implementation choice: register access over APB.
`timescale 1ns/1ps
`include "dti_map.svh"

// Functional notes
// - reading first timer clear register returns zero and clears its interrupt
// - register 0x10 bit 0 shows first timer interrupt state, rest zero
// - register 0x14 holds writable 24-bit second timer reload, resets zero
// - register 0x18 shows live 24-bit second timer count, upper bits zero
// - control bit 2 set suppresses the second timer interrupt
// - control bit 1 picks free-running or reload-value counting
// - control bit 0 at 0x1c enables timer; bits 31 to 3 read zero
// - reading second timer clear register returns zero and clears its interrupt
// - writing enable 0 stops the timer, writing 1 runs it
module dti_regs
   import dti_pkg::*;
(
   input  wire logic        pclk,               // system clock, 20 MHz
   input  wire logic        presetn,            // async reset, active low
   input  wire logic        psel,               // apb select
   input  wire logic        penable,            // apb access phase
   input  wire logic        pwrite,             // apb direction
   input  wire logic [7:0]  paddr,              // apb byte address
   input  wire logic [31:0] pwdata,             // apb write data
   output logic      [31:0] prdata,             // apb read data
   output logic             pready,             // apb ready
   output logic             pslverr,            // apb error, unmapped
   input  wire logic        first_timer_expiry, // first timer wrap pulse
   output logic             irq                 // level interrupt
);

   dti_regs_s q;
   dti_regs_s d;

   logic       setup;
   logic       done;
   logic       wr_done;
   logic       rd_done;
   logic       mapped;
   logic [31:0] rd_word;
   logic [1:0] stat;
   logic [1:0] set_vec;
   logic [1:0] clr_vec;
   logic [1:0] live_vec;
   dti_cnt_t   t2_count;
   logic       t2_expire;

   // apb phases; the answer always comes in the first access cycle
   assign setup   = psel && !penable;
   assign done    = psel && penable && q.pready;
   assign wr_done = done && pwrite;
   assign rd_done = done && !pwrite;

   // second timer counter
   dti_timer24 u_timer2 (
      .pclk    (pclk),
      .presetn (presetn),
      .en      (q.ctrl.en),
      .mode    (q.ctrl.mode),
      .reload  (q.load),
      .count   (t2_count),
      .expire  (t2_expire)
   );

   // the first timer lives outside; its wrap arrives on this clock
   assign set_vec[`DTI_IRQ_T1_BIT] = first_timer_expiry;
   assign set_vec[`DTI_IRQ_T2_BIT] = t2_expire;

   // a status bit clears on its end-of-interrupt read or a one written
   assign clr_vec[`DTI_IRQ_T1_BIT] =
      (rd_done && paddr == `DTI_OFF_T1_EOI) ||
      (wr_done && paddr == `DTI_OFF_IRQ_STAT &&
       pwdata[`DTI_IRQ_T1_BIT]);
   assign clr_vec[`DTI_IRQ_T2_BIT] =
      (rd_done && paddr == `DTI_OFF_T2_EOI) ||
      (wr_done && paddr == `DTI_OFF_IRQ_STAT &&
       pwdata[`DTI_IRQ_T2_BIT]);

   // one sticky flag per timer
   genvar gi;
   generate
      for (gi = 0; gi < `DTI_IRQ_NUM; gi = gi + 1) begin : g_flag
         dti_flag u_flag (
            .pclk    (pclk),
            .presetn (presetn),
            .set     (set_vec[gi]),
            .clr     (clr_vec[gi]),
            .q       (stat[gi])
         );
      end
   endgenerate

   // the control mask gates only the second timer, on top of the mask reg
   assign live_vec[`DTI_IRQ_T1_BIT] = stat[`DTI_IRQ_T1_BIT] &&
                                      !q.mask[`DTI_IRQ_T1_BIT];
   assign live_vec[`DTI_IRQ_T2_BIT] = stat[`DTI_IRQ_T2_BIT] &&
                                      !q.mask[`DTI_IRQ_T2_BIT] &&
                                      !q.ctrl.mask;

   // read mux; reserved bits and clear registers read as zero
   always_comb begin
      rd_word = `DTI_WORD_ZERO;
      mapped  = 1'b1;
      case (paddr)
         `DTI_OFF_T1_EOI: begin
            rd_word = `DTI_WORD_ZERO;
         end
         `DTI_OFF_T1_STAT: begin
            rd_word[`DTI_IRQ_T1_BIT] = stat[`DTI_IRQ_T1_BIT];
         end
         `DTI_OFF_T2_LOAD: begin
            rd_word = {`DTI_PAD_ZERO, q.load};
         end
         `DTI_OFF_T2_COUNT: begin
            rd_word = {`DTI_PAD_ZERO, t2_count};
         end
         `DTI_OFF_T2_CTRL: begin
            rd_word[`DTI_CTRL_EN_BIT]   = q.ctrl.en;
            rd_word[`DTI_CTRL_MODE_BIT] = q.ctrl.mode;
            rd_word[`DTI_CTRL_MASK_BIT] = q.ctrl.mask;
         end
         `DTI_OFF_T2_EOI: begin
            rd_word = `DTI_WORD_ZERO;
         end
         `DTI_OFF_IRQ_STAT: begin
            rd_word[`DTI_IRQ_T1_BIT] = stat[`DTI_IRQ_T1_BIT];
            rd_word[`DTI_IRQ_T2_BIT] = stat[`DTI_IRQ_T2_BIT];
         end
         `DTI_OFF_IRQ_MASK: begin
            rd_word[`DTI_IRQ_T1_BIT] = q.mask[`DTI_IRQ_T1_BIT];
            rd_word[`DTI_IRQ_T2_BIT] = q.mask[`DTI_IRQ_T2_BIT];
         end
         default: begin
            mapped = 1'b0;
         end
      endcase
   end

   // next state: apb answer, writable fields and the interrupt level
   always_comb begin
      d         = q;
      d.pready  = setup;
      d.pslverr = setup && !mapped;
      // data is sampled at setup so it stands still through access
      if (setup && !pwrite) begin
         d.prdata = rd_word;
      end else if (!psel) begin
         d.prdata = `DTI_WORD_ZERO;
      end
      // writes to read-only words are dropped without error
      if (wr_done) begin
         case (paddr)
            `DTI_OFF_T2_LOAD: begin
               d.load = pwdata[`DTI_CNT_MSB:0];
            end
            `DTI_OFF_T2_CTRL: begin
               d.ctrl.en   = pwdata[`DTI_CTRL_EN_BIT];
               d.ctrl.mode = pwdata[`DTI_CTRL_MODE_BIT];
               d.ctrl.mask = pwdata[`DTI_CTRL_MASK_BIT];
            end
            `DTI_OFF_IRQ_MASK: begin
               d.mask[`DTI_IRQ_T1_BIT] = pwdata[`DTI_IRQ_T1_BIT];
               d.mask[`DTI_IRQ_T2_BIT] = pwdata[`DTI_IRQ_T2_BIT];
            end
            default: begin
               d.load = q.load;
            end
         endcase
      end
      // registered so the pin never glitches; lags status by one edge
      d.irq = |live_vec;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign prdata  = q.prdata;
   assign pready  = q.pready;
   assign pslverr = q.pslverr;
   assign irq     = q.irq;

   // ------------------------------------------------------------------
   // checks
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   // clear-register read answers all zeroes
   property p_eoi1_zero;
      (setup && !pwrite && paddr == `DTI_OFF_T1_EOI)
      |=> (pready && prdata == `DTI_WORD_ZERO);
   endproperty
   a_eoi1_zero: assert property (p_eoi1_zero)
      else $error("first clear register read not zero");

   // clear-register read drops the first timer flag
   property p_eoi1_clear;
      (rd_done && paddr == `DTI_OFF_T1_EOI && !first_timer_expiry)
      |=> !stat[`DTI_IRQ_T1_BIT];
   endproperty
   a_eoi1_clear: assert property (p_eoi1_clear)
      else $error("first timer flag survived its clear read");

   // clear-register read of the second timer answers all zeroes
   property p_eoi2_zero;
      (setup && !pwrite && paddr == `DTI_OFF_T2_EOI)
      |=> (pready && prdata == `DTI_WORD_ZERO);
   endproperty
   a_eoi2_zero: assert property (p_eoi2_zero)
      else $error("second clear register read not zero");

   // status word carries the flag in bit 0 only
   property p_t1_stat;
      (setup && !pwrite && paddr == `DTI_OFF_T1_STAT)
      |=> (prdata[31:1] == 31'h0000_0000 &&
           prdata[0] == $past(stat[`DTI_IRQ_T1_BIT]));
   endproperty
   a_t1_stat: assert property (p_t1_stat)
      else $error("first timer status word wrong");

   // reload value follows a write, upper byte dropped
   property p_load_write;
      (wr_done && paddr == `DTI_OFF_T2_LOAD)
      |=> (q.load == $past(pwdata[`DTI_CNT_MSB:0]));
   endproperty
   a_load_write: assert property (p_load_write)
      else $error("reload value not stored");

   // count readback with zero upper byte
   property p_count_read;
      (setup && !pwrite && paddr == `DTI_OFF_T2_COUNT)
      |=> (prdata[31:24] == `DTI_PAD_ZERO &&
           prdata[23:0] == $past(t2_count));
   endproperty
   a_count_read: assert property (p_count_read)
      else $error("live count readback wrong");

   // control mask keeps a lone second timer flag off the pin
   property p_ctrl_mask;
      (q.ctrl.mask && !live_vec[`DTI_IRQ_T1_BIT]) |=> !irq;
   endproperty
   a_ctrl_mask: assert property (p_ctrl_mask)
      else $error("masked second timer reached irq");

   // wrap reloads from the value the mode selects
   property p_wrap_reload;
      (q.ctrl.en && $past(q.ctrl.en) && t2_count == `DTI_CNT_ZERO)
      |=> (t2_expire && t2_count == ($past(q.ctrl.mode) ?
           $past(q.load) : `DTI_CNT_MAX));
   endproperty
   a_wrap_reload: assert property (p_wrap_reload)
      else $error("wrong reload at wrap");

   // control word reads with bits 31 to 3 clear
   property p_ctrl_read;
      (setup && !pwrite && paddr == `DTI_OFF_T2_CTRL)
      |=> (prdata[31:3] == 29'h0000_0000 &&
           prdata[0] == $past(q.ctrl.en));
   endproperty
   a_ctrl_read: assert property (p_ctrl_read)
      else $error("control readback wrong");

   // a stopped timer holds its count
   property p_stop_hold;
      (!q.ctrl.en && !d.ctrl.en) |=> $stable(t2_count);
   endproperty
   a_stop_hold: assert property (p_stop_hold)
      else $error("stopped timer moved");

   // enable write lands on the next edge
   property p_en_write;
      (wr_done && paddr == `DTI_OFF_T2_CTRL)
      |=> (q.ctrl.en == $past(pwdata[`DTI_CTRL_EN_BIT]));
   endproperty
   a_en_write: assert property (p_en_write)
      else $error("enable write not stored");

   // a fresh enable loads the start value that the mode selects
   property p_start_load;
      (q.ctrl.en && !$past(q.ctrl.en))
      |=> (t2_count == ($past(q.ctrl.mode) ?
           $past(q.load) : `DTI_CNT_MAX));
   endproperty
   a_start_load: assert property (p_start_load)
      else $error("wrong start value after enable");

   // a wrap pulse sets the second timer flag on the next edge
   property p_t2_flag_set;
      t2_expire |=> stat[`DTI_IRQ_T2_BIT];
   endproperty
   a_t2_flag_set: assert property (p_t2_flag_set)
      else $error("wrap did not set second timer flag");

   // running timer steps down by one away from zero
   property p_decrement;
      (q.ctrl.en && $past(q.ctrl.en) && t2_count != `DTI_CNT_ZERO)
      |=> (t2_count == $past(t2_count) - `DTI_CNT_ONE);
   endproperty
   a_decrement: assert property (p_decrement)
      else $error("timer did not decrement");

   // clear-register read drops the second timer flag
   property p_eoi2_clear;
      (rd_done && paddr == `DTI_OFF_T2_EOI && !t2_expire)
      |=> !stat[`DTI_IRQ_T2_BIT];
   endproperty
   a_eoi2_clear: assert property (p_eoi2_clear)
      else $error("second timer flag survived its clear read");

   // unmasked flag raises irq on the next edge and holds without clears
   property p_irq_level;
      (live_vec != 2'b00) |=> irq;
   endproperty
   a_irq_level: assert property (p_irq_level)
      else $error("irq missing for live status");

   // no live status drops irq on the next edge
   property p_irq_quiet;
      (live_vec == 2'h0) |=> !irq;
   endproperty
   a_irq_quiet: assert property (p_irq_quiet)
      else $error("irq high without live status");

   property p_flag_sticky;
      (stat[`DTI_IRQ_T1_BIT] && !clr_vec[`DTI_IRQ_T1_BIT])
      |=> stat[`DTI_IRQ_T1_BIT];
   endproperty
   a_flag_sticky: assert property (p_flag_sticky)
      else $error("first timer flag dropped on its own");

   // main scenarios
   c_wrap_user: cover property (
      q.ctrl.en && q.ctrl.mode && t2_expire);
   c_wrap_free: cover property (
      q.ctrl.en && !q.ctrl.mode && t2_expire);
   c_eoi_clear: cover property (
      stat[`DTI_IRQ_T2_BIT] && rd_done && paddr == `DTI_OFF_T2_EOI);
   c_set_clear: cover property (
      set_vec[`DTI_IRQ_T1_BIT] && clr_vec[`DTI_IRQ_T1_BIT]);

endmodule // dti_regs

/* File: test/tb_top.sv */
`timescale 1ns/1ps
`include "dti_map.svh"

module tb_top
   import dti_pkg::*;
;
   logic        pclk;
   logic        presetn;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [7:0]  paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        first_timer_expiry;
   logic        irq;
   int          error_cnt;
   int          checks_done;
   logic [31:0] rd;
   logic [31:0] rd2;
   logic        err;

   dti_regs dut (
      .pclk               (pclk),
      .presetn            (presetn),
      .psel               (psel),
      .penable            (penable),
      .pwrite             (pwrite),
      .paddr              (paddr),
      .pwdata             (pwdata),
      .prdata             (prdata),
      .pready             (pready),
      .pslverr            (pslverr),
      .first_timer_expiry (first_timer_expiry),
      .irq                (irq)
   );

   // 20 MHz clock
   always #25 pclk = ~pclk;

   // single comparison point, counts every call
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         error_cnt++;
         $display("unexpected at %0t seen %h exp %h", $time, seen, exp);
      end
   endtask

   // one apb transfer; waits for pready, never assumes a latency
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] r,
                      output logic e);
      int n;
      n = 0;
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) begin
         chk(32'h0000_0001, 32'h0000_0000);
      end
      r = prdata;
      e = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic        e;
      apb(1'b1, a, d, r, e);
      chk({31'h0, e}, 32'h0000_0000);
   endtask

   task automatic rdw(input logic [7:0] a, output logic [31:0] r);
      logic e;
      apb(1'b0, a, 32'h0000_0000, r, e);
      chk({31'h0, e}, 32'h0000_0000);
   endtask

   // wait a bounded time for irq to reach a level
   task automatic wait_irq(input logic v, input int lim);
      int n;
      for (n = 0; n < lim && irq !== v; n++) begin
         @(posedge pclk);
      end
      chk({31'h0, irq}, {31'h0, v});
   endtask

   // every word reads zero straight out of reset
   task automatic t_reset_values();
      logic [7:0] a [8] = '{8'h0c, 8'h10, 8'h14, 8'h18,
                            8'h1c, 8'h20, 8'h24, 8'h28};
      foreach (a[i]) begin
         rdw(a[i], rd);
         chk(rd, 32'h0000_0000);
      end
      chk({31'h0, irq}, 32'h0000_0000);
      $display("test reset_values done");
   endtask

   // upper bits of reload and control never stick; unmapped errors
   task automatic t_field_widths();
      wr(`DTI_OFF_T2_LOAD, 32'hffff_ffff);
      rdw(`DTI_OFF_T2_LOAD, rd);
      chk(rd, 32'h00ff_ffff);
      wr(`DTI_OFF_T2_CTRL, 32'hffff_fff8);
      rdw(`DTI_OFF_T2_CTRL, rd);
      chk(rd, 32'h0000_0000);
      wr(`DTI_OFF_T1_STAT, 32'hffff_ffff);
      rdw(`DTI_OFF_T1_STAT, rd);
      chk(rd, 32'h0000_0000);
      apb(1'b0, 8'h04, 32'h0000_0000, rd, err);
      chk({31'h0, err}, 32'h0000_0001);
      $display("test field_widths done");
   endtask

   // first timer event: sticky, maskable, cleared by read
   task automatic t_first_timer();
      @(posedge pclk);
      first_timer_expiry <= 1'b1;
      @(posedge pclk);
      first_timer_expiry <= 1'b0;
      repeat (4) @(posedge pclk);
      chk({31'h0, irq}, 32'h0000_0001);
      rdw(`DTI_OFF_T1_STAT, rd);
      chk(rd, 32'h0000_0001);
      wr(`DTI_OFF_IRQ_MASK, 32'h0000_0001);
      wait_irq(1'b0, 3);
      wr(`DTI_OFF_IRQ_MASK, 32'h0000_0000);
      wait_irq(1'b1, 3);
      rdw(`DTI_OFF_T1_EOI, rd);
      chk(rd, 32'h0000_0000);
      rdw(`DTI_OFF_T1_STAT, rd);
      chk(rd, 32'h0000_0000);
      wait_irq(1'b0, 3);
      $display("test first_timer done");
   endtask

   // reload-value mode wraps, clear by read, then mask suppresses irq
   task automatic t_second_timer();
      wr(`DTI_OFF_T2_LOAD, 32'h0000_0005);
      wr(`DTI_OFF_T2_CTRL, 32'h0000_0003);
      rdw(`DTI_OFF_T2_COUNT, rd);
      chk({31'h0, rd <= 32'h0000_0005}, 32'h0000_0001);
      wait_irq(1'b1, 30);
      rdw(`DTI_OFF_T2_COUNT, rd);
      chk({31'h0, rd <= 32'h0000_0005}, 32'h0000_0001);
      rdw(`DTI_OFF_T2_EOI, rd);
      chk(rd, 32'h0000_0000);
      wr(`DTI_OFF_T2_CTRL, 32'h0000_0007);
      rdw(`DTI_OFF_T2_CTRL, rd);
      chk(rd, 32'h0000_0007);
      repeat (20) @(posedge pclk);
      chk({31'h0, irq}, 32'h0000_0000);
      rdw(`DTI_OFF_IRQ_STAT, rd);
      chk(rd & 32'h0000_0002, 32'h0000_0002);
      wr(`DTI_OFF_T2_CTRL, 32'h0000_0006);
      rdw(`DTI_OFF_T2_COUNT, rd);
      repeat (5) @(posedge pclk);
      rdw(`DTI_OFF_T2_COUNT, rd2);
      chk(rd2, rd);
      wr(`DTI_OFF_IRQ_STAT, 32'h0000_0002);
      rdw(`DTI_OFF_IRQ_STAT, rd);
      chk(rd, 32'h0000_0000);
      wr(`DTI_OFF_T2_CTRL, 32'h0000_0000);
      $display("test second_timer done");
   endtask

   // free-running mode starts from the 24-bit maximum and counts down
   task automatic t_free_running();
      wr(`DTI_OFF_T2_CTRL, 32'h0000_0001);
      rdw(`DTI_OFF_T2_COUNT, rd);
      chk(rd & 32'hffff_ff00, 32'h00ff_ff00);
      rdw(`DTI_OFF_T2_COUNT, rd2);
      chk({31'h0, rd2 < rd}, 32'h0000_0001);
      wr(`DTI_OFF_T2_CTRL, 32'h0000_0000);
      rdw(`DTI_OFF_T2_COUNT, rd);
      repeat (4) @(posedge pclk);
      rdw(`DTI_OFF_T2_COUNT, rd2);
      chk(rd2, rd);
      chk({31'h0, irq}, 32'h0000_0000);
      $display("test free_running done");
   endtask

   // the single place where the run ends
   task automatic final_report();
      $display("checks %0d mismatches %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   // watchdog, far beyond the few hundred cycles the tests take
   initial begin
      repeat (20000) @(posedge pclk);
      error_cnt++;
      final_report();
   end

   // main sequence
   initial begin
      pclk               = 1'b0;
      presetn            = 1'b0;
      psel               = 1'b0;
      penable            = 1'b0;
      pwrite             = 1'b0;
      paddr              = 8'h00;
      pwdata             = 32'h0000_0000;
      first_timer_expiry = 1'b0;
      error_cnt          = 0;
      checks_done        = 0;
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      t_reset_values();
      t_field_widths();
      t_first_timer();
      t_second_timer();
      t_free_running();
      final_report();
   end
endmodule // tb_top
